// ### mp_topo_pkg.sv
package mp_topo_pkg;

	// ****************************************
	// register offsets on the plain port
	// ****************************************
	localparam logic [7:0] off_local_id     = 8'h02; // processor_interrupt_identifier
	localparam logic [7:0] off_spurious     = 8'h0f; // spurious_vector_register
	localparam logic [7:0] off_cmd_low      = 8'h30; // interrupt_command_register low
	localparam logic [7:0] off_cmd_high     = 8'h31; // interrupt_command_register high
	localparam logic [7:0] off_error_entry  = 8'h37; // error_vector_entry
	localparam logic [7:0] off_status       = 8'h40; // run state and wake vector
	localparam logic [7:0] off_query_eax    = 8'h50; // identification_query leaf 1 eax
	localparam logic [7:0] off_query_ebx    = 8'h51; // identification_query leaf 1 ebx
	localparam logic [7:0] off_query_edx    = 8'h53; // identification_query leaf 1 edx
	localparam logic [7:0] off_query_l4_eax = 8'h54; // identification_query leaf 4 eax
	localparam logic [7:0] off_system_management_base       = 8'h60; // system_management_base

	// ****************************************
	// field positions
	// ****************************************
	localparam int spur_enable_bit   = 8;
	localparam int local_id_lsb      = 24;
	localparam int ebx_id_lsb        = 24;
	localparam int ebx_count_lsb     = 16;
	localparam int edx_mt_bit        = 28;
	localparam int l4_cores_lsb      = 26;
	localparam int cmd_mode_lsb      = 8;
	localparam int cmd_dest_lsb      = 24;
	localparam int cmd_pending_bit   = 12;
	localparam int start_page_lsb    = 12;

	// ****************************************
	// reset values and encodings
	// ****************************************
	localparam logic [31:0] spur_reset     = 32'h0000_00ff; // enable bit clear
	localparam logic [31:0] error_reset    = 32'h0001_0000; // masked
	localparam logic [31:0] zero_word      = 32'h0000_0000;
	localparam logic [31:0] reset_fetch    = 32'hffff_fff0;
	localparam logic [2:0]  mode_fixed     = 3'h0;
	localparam logic [2:0]  mode_init      = 3'h5;
	localparam logic [2:0]  mode_startup   = 3'h6;
	localparam logic [7:0]  one_logical    = 8'h01;
	localparam logic [31:0] family_sig     = 32'h0000_0600; // arbitrary value

	typedef enum logic [1:0] {
		run_idle_type_unused
	} unused_type;

	typedef enum {
		st_wait_init,
		st_wait_startup,
		st_running,
		st_halted
	} run_state_type;

	// keep a power-up identifier aligned to its hierarchy fields
	function automatic logic [7:0] make_id(input logic [1:0] cluster,
		input logic [1:0] pkg, input logic thread, input logic mt, input logic old_family);
		logic [7:0] id;
		id = 8'h00;
		if (old_family) begin
			id = {4'h0, cluster, pkg};
		end else begin
			id = {3'h0, cluster, pkg, thread & mt};
		end
		return id;
	endfunction

endpackage

// ### mp_topology_startup.sv
`timescale 1ns/10ps
module mp_topology_startup
	import mp_topo_pkg::*;
(
	input  wire logic        sys_clk,
	input  wire logic        rst_b,
	input  wire logic [7:0]  reg_addr,
	input  wire logic [31:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [31:0] reg_rdata,
	input  wire logic [1:0]  strap_cluster,
	input  wire logic [1:0]  strap_package,
	input  wire logic        strap_thread,
	input  wire logic        strap_mt,
	input  wire logic        strap_old_family,
	input  wire logic [7:0]  strap_logical_count,
	input  wire logic [5:0]  strap_cores_m1,
	input  wire logic        msg_in_valid,
	input  wire logic [2:0]  msg_in_mode,
	input  wire logic [7:0]  msg_in_dest,
	input  wire logic        msg_in_broadcast,
	input  wire logic [7:0]  msg_in_vector,
	output logic             msg_out_valid,
	output logic      [2:0]  msg_out_mode,
	output logic      [7:0]  msg_out_dest,
	output logic      [7:0]  msg_out_vector,
	output logic             fetch_start,
	output logic      [31:0] fetch_addr,
	output logic             halted,
	output logic             ctrl_enabled
);

	// ****************************************
	// state
	// ****************************************
	logic [7:0]    powerup_id_ff;
	logic          captured_ff;
	logic [7:0]    local_id_ff;
	logic [31:0]   spurious_ff;
	logic [31:0]   error_entry_ff;
	logic [31:0]   cmd_high_ff;
	logic [31:0]   system_management_base_ff;
	logic [7:0]    wake_vector_ff;
	run_state_type state_ff;
	run_state_type nxt_state;

	// ****************************************
	// decode
	// ****************************************
	wire logic [7:0] strap_id    = make_id(strap_cluster, strap_package, strap_thread,
		strap_mt, strap_old_family);
	// write strobes, one per writable offset
	wire logic wr_local   = wr_hit(reg_wr, reg_addr, off_local_id);
	wire logic wr_spur    = wr_hit(reg_wr, reg_addr, off_spurious);
	wire logic wr_err     = wr_hit(reg_wr, reg_addr, off_error_entry);
	wire logic wr_cmd_lo  = wr_hit(reg_wr, reg_addr, off_cmd_low);
	wire logic wr_cmd_hi  = wr_hit(reg_wr, reg_addr, off_cmd_high);
	wire logic wr_system_management_base  = wr_hit(reg_wr, reg_addr, off_system_management_base);
	wire logic enabled    = spurious_ff[spur_enable_bit];
	wire logic for_me     = msg_in_valid && enabled
		&& (msg_in_broadcast || (msg_in_dest == local_id_ff));
	wire logic got_init   = for_me && (msg_in_mode == mode_init);
	wire logic got_start  = for_me && (msg_in_mode == mode_startup);
	wire logic got_fixed  = for_me && (msg_in_mode == mode_fixed);
	wire logic start_now  = got_start && (state_ff == st_wait_startup);
	wire logic wake_now   = got_fixed && (state_ff == st_halted);
	// halt request only counts while the processor is running
	wire logic halt_req   = wr_hit(reg_wr, reg_addr, off_status) && reg_wdata[0];
	wire logic [31:0] ebx_word = {powerup_id_ff, one_logical_or(strap_logical_count),
		16'h0000};
	wire logic [31:0] edx_word = strap_mt ? (32'h1 << edx_mt_bit) : zero_word;
	wire logic [31:0] l4_word  = {strap_cores_m1, 26'h0000000};
	wire logic [31:0] status_word = {16'h0000, wake_vector_ff, 6'h00,
		state_ff == st_running, state_ff == st_halted};

	// a manufactured count of zero would be meaningless; report at least one
	function automatic logic [7:0] one_logical_or(input logic [7:0] cnt);
		return (cnt == 8'h00) ? one_logical : cnt;
	endfunction

	// write strobe aimed at one offset; all inputs passed in so the
	// continuous assignments that call it see every change
	function automatic logic wr_hit(input logic strobe, input logic [7:0] addr,
		input logic [7:0] offset);
		return strobe && (addr == offset);
	endfunction

	// read data selection
	logic [31:0] rd_mux;
	always_comb begin
		unique case (reg_addr)
			off_local_id:     rd_mux = {local_id_ff, 24'h000000};
			off_spurious:     rd_mux = spurious_ff;
			off_cmd_low:      rd_mux = {19'h00000, msg_out_valid, 1'b0, msg_out_mode,
				msg_out_vector};
			off_cmd_high:     rd_mux = cmd_high_ff;
			off_error_entry:  rd_mux = error_entry_ff;
			off_status:       rd_mux = status_word;
			off_query_eax:    rd_mux = family_sig;
			off_query_ebx:    rd_mux = ebx_word;
			off_query_edx:    rd_mux = edx_word;
			off_query_l4_eax: rd_mux = l4_word;
			off_system_management_base:       rd_mux = system_management_base_ff;
			default:          rd_mux = zero_word;
		endcase
	end

	// ****************************************
	// run state
	// ****************************************
	always_comb begin
		nxt_state = state_ff;
		unique case (state_ff)
			st_wait_init:    if (got_init) nxt_state = st_wait_startup;
			st_wait_startup: if (got_start) nxt_state = st_running;
			st_running:      if (halt_req) nxt_state = st_halted;
			st_halted: begin
				if (got_init) nxt_state = st_wait_startup;
				else if (got_fixed) nxt_state = st_running;
			end
		endcase
	end

	// ****************************************
	// power-up identifier
	// ****************************************
	// capture flag: set on the first edge after reset release, then held
	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			captured_ff <= 1'b0;
		end else begin
			captured_ff <= 1'b1;
		end
	end

	// power-up identifier caught once, then frozen until the next reset;
	// no write path reaches it, so rewriting the local id leaves it alone
	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			powerup_id_ff <= 8'h00;
		end else if (!captured_ff) begin
			powerup_id_ff <= strap_id;
		end
	end

	// ****************************************
	// software-visible controller registers
	// ****************************************
	// local identifier starts as the power-up value, later writable
	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			local_id_ff <= 8'h00;
		end else if (!captured_ff) begin
			local_id_ff <= strap_id;
		end else if (wr_local) begin
			local_id_ff <= reg_wdata[local_id_lsb +: 8];
		end
	end

	// spurious vector register; its enable bit gates all incoming messages
	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			spurious_ff <= spur_reset;
		end else if (wr_spur) begin
			spurious_ff <= reg_wdata;
		end
	end

	// error entry comes out of reset masked
	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			error_entry_ff <= error_reset;
		end else if (wr_err) begin
			error_entry_ff <= reg_wdata;
		end
	end

	// command high word holds the destination for the next send
	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			cmd_high_ff <= zero_word;
		end else if (wr_cmd_hi) begin
			cmd_high_ff <= reg_wdata;
		end
	end

	// system management base, one per processor, set by software
	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			system_management_base_ff <= zero_word;
		end else if (wr_system_management_base) begin
			system_management_base_ff <= reg_wdata;
		end
	end

	// ****************************************
	// outgoing message
	// ****************************************
	// one valid cycle per write of the command low word
	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			msg_out_valid <= 1'b0;
		end else begin
			msg_out_valid <= wr_cmd_lo;
		end
	end

	// delivery mode, held after the valid cycle
	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			msg_out_mode <= mode_fixed;
		end else if (wr_cmd_lo) begin
			msg_out_mode <= reg_wdata[cmd_mode_lsb +: 3];
		end
	end

	// destination taken from the high word written beforehand
	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			msg_out_dest <= 8'h00;
		end else if (wr_cmd_lo) begin
			msg_out_dest <= cmd_high_ff[cmd_dest_lsb +: 8];
		end
	end

	// vector byte of the command low word
	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			msg_out_vector <= 8'h00;
		end else if (wr_cmd_lo) begin
			msg_out_vector <= reg_wdata[7:0];
		end
	end

	// ****************************************
	// run state and fetch
	// ****************************************
	// run state register
	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			state_ff <= st_wait_init;
		end else begin
			state_ff <= nxt_state;
		end
	end

	// vector of the message that last woke a halted processor
	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			wake_vector_ff <= 8'h00;
		end else if (wake_now) begin
			wake_vector_ff <= msg_in_vector;
		end
	end

	// fetch pulse on a start or a wake, one cycle long
	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			fetch_start <= 1'b0;
		end else begin
			fetch_start <= start_now || wake_now;
		end
	end

	// fetch address: reset vector, then the start page of the message
	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			fetch_addr <= reset_fetch;
		end else if (start_now) begin
			fetch_addr <= {12'h000, msg_in_vector, 12'h000};
		end
	end

	// halted level follows the next state so software sees it at once
	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			halted <= 1'b0;
		end else begin
			halted <= (nxt_state == st_halted);
		end
	end

	// controller enable pin mirrors the spurious enable bit
	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			ctrl_enabled <= 1'b0;
		end else begin
			ctrl_enabled <= wr_spur ? reg_wdata[spur_enable_bit] : enabled;
		end
	end

	// ****************************************
	// read port
	// ****************************************
	// read data stand one cycle after the strobe, zero otherwise
	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			reg_rdata <= zero_word;
		end else begin
			reg_rdata <= reg_rd ? rd_mux : zero_word;
		end
	end

endmodule

// ### mp_topology_startup_props.sv
`timescale 1ns/10ps
// ****
// port checks
// ****
module mp_topology_startup_props
	import mp_topo_pkg::*;
(
	input wire logic        sys_clk,
	input wire logic        rst_b,
	input wire logic [7:0]  reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic        reg_wr,
	input wire logic        reg_rd,
	input wire logic [31:0] reg_rdata,
	input wire logic [1:0]  strap_cluster,
	input wire logic [1:0]  strap_package,
	input wire logic        strap_thread,
	input wire logic        strap_mt,
	input wire logic        strap_old_family,
	input wire logic [7:0]  strap_logical_count,
	input wire logic [5:0]  strap_cores_m1,
	input wire logic        msg_out_valid,
	input wire logic [2:0]  msg_out_mode,
	input wire logic [7:0]  msg_out_vector,
	input wire logic        fetch_start,
	input wire logic [31:0] fetch_addr,
	input wire logic        ctrl_enabled
);
	logic [15:0] idc;
	// identifier and count expected from the straps
	assign idc = {strap_old_family ? {4'h0, strap_cluster, strap_package}
		: {3'h0, strap_cluster, strap_package, strap_thread & strap_mt},
		(strap_logical_count == 8'h00) ? one_logical : strap_logical_count};
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_b);
	a_ctrl_reset: assert property (disable iff (1'b0) !rst_b |=> !ctrl_enabled)
		else $error("enable set after reset");
	a_ctrl_write: assert property (reg_wr && reg_addr == off_spurious
		|=> ctrl_enabled == $past(reg_wdata[spur_enable_bit])) else $error("enable copy");
	a_id_report: assert property (reg_rd && reg_addr == off_query_ebx
		|=> reg_rdata[31:16] == idc) else $error("id or count field");
	a_mt_flag: assert property (reg_rd && reg_addr == off_query_edx
		|=> reg_rdata[edx_mt_bit] == strap_mt) else $error("thread flag");
	a_core_count: assert property (reg_rd && reg_addr == off_query_l4_eax
		|=> reg_rdata[31:26] == strap_cores_m1) else $error("core count");
	a_msg_fields: assert property (reg_wr && reg_addr == off_cmd_low |=> msg_out_valid
		&& msg_out_mode == $past(reg_wdata[10:8]) && msg_out_vector == $past(reg_wdata[7:0]))
		else $error("message fields");
	a_msg_cause: assert property (msg_out_valid |-> $past(reg_wr && reg_addr == off_cmd_low))
		else $error("stray message");
	a_fetch_page: assert property (fetch_start
		|-> fetch_addr[31:20] == 12'h000 && fetch_addr[11:0] == 12'h000) else $error("fetch page");
endmodule

// ### mp_fabric_model.sv
`timescale 1ns/10ps
// ****
// interrupt message fabric
// ****
module mp_fabric_model (
	input wire logic       sys_clk,
	output logic           msg_in_valid,
	output logic     [2:0] msg_in_mode,
	output logic     [7:0] msg_in_dest,
	output logic           msg_in_broadcast,
	output logic     [7:0] msg_in_vector,
	input wire logic       msg_out_valid,
	input wire logic [2:0] msg_out_mode,
	input wire logic [7:0] msg_out_dest,
	input wire logic [7:0] msg_out_vector
);
	logic [20:0] drv = 21'h0;
	logic [18:0] last;
	assign {msg_in_valid, msg_in_mode, msg_in_dest, msg_in_broadcast, msg_in_vector} = drv;
	// one message for one cycle to a target, fields inverted once released
	task send(input logic [2:0] m, input logic [7:0] t, input logic b, input logic [7:0] v,
		input int gap);
		repeat (gap + 1) @(posedge sys_clk);
		drv <= {1'b1, m, t, b, v};
		@(posedge sys_clk);
		drv <= {1'b0, ~m, ~t, ~b, ~v};
	endtask
	// last message sent by the block
	always @(posedge sys_clk) if (msg_out_valid === 1'b1) last = {msg_out_mode, msg_out_dest, msg_out_vector};
endmodule

// ### test_mp_topology_startup.sv
`timescale 1ns/10ps
// ****
// bench
// ****
module test_mp_topology_startup
	import mp_topo_pkg::*;
;
	logic        sys_clk, rst_b, reg_wr, reg_rd, strap_thread, strap_mt, strap_old_family;
	logic        msg_in_valid, msg_in_broadcast, msg_out_valid, fetch_start, halted, ctrl_enabled;
	logic [1:0]  strap_cluster, strap_package;
	logic [2:0]  msg_in_mode, msg_out_mode;
	logic [5:0]  strap_cores_m1;
	logic [7:0]  reg_addr, strap_logical_count, msg_in_dest, msg_in_vector, v, w;
	logic [7:0]  msg_out_dest, msg_out_vector;
	logic [31:0] reg_wdata, reg_rdata, fetch_addr, d;
	int          num_errors, checked, nfetch, k;
	integer      seed = 32'h691bd439;
	logic [2:0]  modes [3] = '{mode_fixed, mode_init, mode_startup};
	mp_topology_startup dut (.*);
	mp_fabric_model fab (.*);
	// clock and fetch pulse count
	initial begin
		sys_clk = 1'b0;
		forever #12.5 sys_clk = ~sys_clk;
	end
	always @(posedge sys_clk) if (fetch_start === 1'b1) nfetch++;
	// identifier and logical count expected from the straps
	function automatic logic [15:0] exp_idc();
		return {strap_old_family ? {4'h0, strap_cluster, strap_package}
			: {3'h0, strap_cluster, strap_package, strap_thread & strap_mt},
			(strap_logical_count == 8'h00) ? 8'h01 : strap_logical_count};
	endfunction
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			num_errors++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task wr(input logic [7:0] a, input logic [31:0] x);
		@(posedge sys_clk);
		{reg_addr, reg_wdata, reg_wr} <= {a, x, 1'b1};
		@(posedge sys_clk);
		reg_wr <= 1'b0;
	endtask
	task rd(input logic [7:0] a, output logic [31:0] r);
		@(posedge sys_clk);
		{reg_addr, reg_rd} <= {a, 1'b1};
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		#1 r = reg_rdata;
	endtask
	task final_report;
		$display("errors %0d checks %0d", num_errors, checked);
		if (num_errors == 0 && checked > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	// strap corners, then messages, commands and registers
	initial begin
		{rst_b, reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
		for (k = 0; k < 4; k++) begin
			@(posedge sys_clk);
			d = $random(seed);
			{strap_cluster, strap_package} <= d[3:0];
			strap_thread <= d[4] | (k == 2);
			strap_mt <= d[5] & (k != 2);
			strap_old_family <= (k == 1);
			strap_logical_count <= (k == 0) ? 8'h00 : d[15:8];
			strap_cores_m1 <= d[21:16];
			rst_b <= 1'b0;
			repeat (3) @(posedge sys_clk);
			rst_b <= 1'b1;
			rd(off_spurious, d); chk(d, spur_reset);
			chk(ctrl_enabled, 1'b0);
			rd(off_error_entry, d); chk(d, error_reset);
			rd(off_query_ebx, d); chk(d[31:16], exp_idc());
			rd(off_query_edx, d); chk(d[edx_mt_bit], strap_mt);
			rd(off_query_l4_eax, d); chk(d[31:26], strap_cores_m1);
			rd(off_local_id, d); chk(d, {8'(exp_idc() >> 8), 24'h0});
			v = $random(seed);
			wr(off_local_id, {v, 24'h0});
			wr(off_query_ebx, ~d);
			rd(off_query_ebx, d); chk(d[31:16], exp_idc());
		end
		k = nfetch;
		fab.send(mode_init, v, 1'b0, 8'h00, 0);
		fab.send(mode_startup, v, 1'b0, 8'h5a, 0);
		wr(off_spurious, spur_reset | 32'h0000_0100);
		wr(off_error_entry, 32'h0000_00e3);
		rd(off_error_entry, d); chk(d, 32'h0000_00e3);
		fab.send(mode_startup, v, 1'b0, 8'h5a, 0);
		repeat (4) @(posedge sys_clk);
		#1 chk(nfetch, k);
		w = $random(seed);
		fab.send(mode_init, ~v, 1'b1, 8'h00, 2);
		fab.send(mode_startup, v, 1'b0, w, 0);
		repeat (8) if (nfetch == k) @(posedge sys_clk);
		#1 chk(nfetch, k + 1);
		chk(fetch_addr, {12'h000, w, 12'h000});
		wr(off_status, 32'h0000_0001);
		#1 chk(halted, 1'b1);
		fab.send(mode_fixed, ~v, 1'b0, 8'h44, 0);
		repeat (3) @(posedge sys_clk);
		#1 chk(halted, 1'b1);
		fab.send(mode_fixed, v, 1'b0, w ^ 8'h81, 1);
		repeat (3) @(posedge sys_clk);
		#1 chk(halted, 1'b0);
		rd(off_status, d); chk({d[15:8], d[1:0]}, {w ^ 8'h81, 2'b10});
		foreach (modes[i]) begin
			w = $random(seed);
			d = $random(seed);
			wr(off_cmd_high, {d[7:0], 24'h0});
			wr(off_cmd_low, {21'h0, modes[i], w});
			@(posedge sys_clk);
			#1 chk(fab.last, {modes[i], d[7:0], w});
		end
		rd(8'h7f, d); chk(d, 32'h0);
		k = $random(seed);
		wr(off_system_management_base, k);
		rd(off_system_management_base, d); chk(d, k);
		final_report;
	end
endmodule
bind mp_topology_startup mp_topology_startup_props chk (.*);
